// *** core/pbm_phy_basic_mode_control.sv ***
// basic mode control register of the fast ethernet phy, apb slave
`timescale 1ns/10ps
module pbm_phy_basic_mode_control #(
  parameter int unsigned DEAD_CYCLES = pbm_pkg::DEAD_CYC,
  parameter int unsigned RST_CYCLES = pbm_pkg::RST_CYC
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pbm_pkg::ADDR_W-1:0] paddr,
  input wire logic [pbm_pkg::DATA_W-1:0] pwdata,
  output logic [pbm_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // from the auto-negotiation engine (asynchronous)
  input wire logic an_ack,
  input wire logic an_speed_100,
  input wire logic an_full_duplex,
  // to the phy datapath and auto-negotiation engine
  output logic phy_soft_reset,
  output logic loopback_en,
  output logic link_speed_100,
  output logic link_full_duplex,
  output logic an_enable,
  output logic an_restart,
  output logic power_down,
  output logic mac_rx_hold
);

  // synchronised engine inputs
  logic [pbm_pkg::SYNC_W-1:0] an_in;
  logic [pbm_pkg::SYNC_W-1:0] an_s;
  logic ack_s;
  logic ack_q;
  logic spd_s;
  logic dup_s;
  logic [1:0] fill;
  logic neg_speed;
  logic neg_duplex;

  // control fields
  logic speed_sel;
  logic duplex_sel;

  // apb decode
  logic setup;
  logic access;
  logic hit_ctl;
  logic hit_stat;
  logic wr_ctl;
  logic [pbm_pkg::DATA_W-1:0] rd_mux;
  logic hit_any;
  logic next_pready;
  logic next_pslverr;
  logic [pbm_pkg::DATA_W-1:0] next_prdata;

  // control write path
  logic rst_busy;
  logic rst_start;
  logic defaults;
  logic w_loop;
  logic w_an_en;
  logic ack_rise;
  logic restart_set;
  logic dead_start;
  logic dead_busy;
  logic next_speed;
  logic next_duplex;
  logic next_loop;
  logic next_speed_sel;
  logic next_an_en;
  logic next_pwdn;
  logic next_duplex_sel;
  logic next_restart;
  logic [pbm_pkg::CTL_W-1:0] ctl_rd;
  logic [pbm_pkg::DATA_W-1:0] stat_rd;

  assign an_in = {an_full_duplex, an_speed_100, an_ack};

  // engine signals cross from the phy side through two flops each
  pbm_sync #(
    .W(pbm_pkg::SYNC_W)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din(an_in),
    .dout(an_s)
  );

  // split the synchronised bundle back into its signals
  assign ack_s = an_s[0];
  assign spd_s = an_s[1];
  assign dup_s = an_s[2];

  // negotiated values read as reset defaults until the synchroniser
  // holds a real sample; without this the first read after reset
  // would show a false 10 Mbps half duplex result
  assign neg_speed = fill[1] ? spd_s : pbm_pkg::SPEED_RST;
  assign neg_duplex = fill[1] ? dup_s : pbm_pkg::DUPLEX_RST;

  // fill marker shifts in ones in step with the two synchroniser stages
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fill <= 2'b00;
    end else begin
      fill <= {fill[0], 1'b1};
    end
  end

  // apb phases; the slave answers with no wait state
  assign setup = psel & ~penable;
  assign access = psel & penable & pready;
  assign hit_ctl = (paddr == pbm_pkg::CTL_ADDR);
  assign hit_stat = (paddr == pbm_pkg::STAT_ADDR);
  assign wr_ctl = access & pwrite & hit_ctl;
  assign hit_any = hit_ctl | hit_stat;

  // a reset request is taken only when no reset is already running;
  // the other fields of that same write are dropped, bit 15 wins
  assign rst_start = wr_ctl & pwdata[pbm_pkg::RST_BIT] & ~rst_busy;
  assign defaults = rst_start | rst_busy;

  // internal reset sequence; its busy flag also drives phy_soft_reset
  pbm_timer #(
    .CYCLES(RST_CYCLES)
  ) u_rst_seq (
    .pclk(pclk),
    .presetn(presetn),
    .start(rst_start),
    .clr(1'b0),
    .busy(rst_busy)
  );

  assign phy_soft_reset = rst_busy;

  // written values used by the control path
  assign w_loop = pwdata[pbm_pkg::LOOP_BIT];
  assign w_an_en = pwdata[pbm_pkg::AN_EN_BIT];

  // restart requested only with autoneg left on by the same write
  assign restart_set = wr_ctl & ~defaults
    & pwdata[pbm_pkg::RESTART_BIT] & w_an_en;

  // engine acknowledges the new negotiation with a rising edge
  assign ack_rise = ack_s & ~ack_q;

  // loopback turned on while the link runs at 100 Mbps
  // limitation: the speed seen is the one before this write, so a
  // write that enables loopback and drops to 10 Mbps still starts it
  assign dead_start = wr_ctl & ~defaults & w_loop & ~loopback_en
    & link_speed_100;

  // dead time; the descrambler may lose lock, so rx stays held
  pbm_timer #(
    .CYCLES(DEAD_CYCLES)
  ) u_dead (
    .pclk(pclk),
    .presetn(presetn),
    .start(dead_start),
    .clr(defaults),
    .busy(dead_busy)
  );

  // resolved link mode: negotiated when autoneg on, else forced bits
  assign next_speed = an_enable ? neg_speed : speed_sel;
  assign next_duplex = an_enable ? neg_duplex : duplex_sel;

  // control register read value; reserved bits are tied low
  assign ctl_rd = {
    rst_busy,
    loopback_en,
    an_enable ? neg_speed : speed_sel,
    an_enable,
    power_down,
    1'b0,
    an_restart,
    an_enable ? neg_duplex : duplex_sel,
    8'h00
  };

  // status register shows the block's own state
  assign stat_rd = {
    27'h0000000,
    link_full_duplex,
    link_speed_100,
    dead_busy,
    an_restart,
    rst_busy
  };

  assign rd_mux = hit_ctl ? {16'h0000, ctl_rd}
    : hit_stat ? stat_rd
    : 32'h00000000;

  // engine acknowledge history for edge detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= ack_s;
    end
  end

  // apb answer, loaded in the setup cycle so it stands in access;
  // read data is zero outside a read so the bus never shows old data
  assign next_pready = setup;
  assign next_pslverr = setup & ~hit_any;
  assign next_prdata = (setup & ~pwrite) ? rd_mux : 32'h00000000;

  // apb answer flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= next_pready;
      pslverr <= next_pslverr;
      prdata <= next_prdata;
    end
  end

  // next field values; the reset sequence holds every field at default
  assign next_loop = defaults ? pbm_pkg::LOOP_RST
    : wr_ctl ? w_loop : loopback_en;
  assign next_speed_sel = defaults ? pbm_pkg::SPEED_RST
    : wr_ctl ? pwdata[pbm_pkg::SPEED_BIT] : speed_sel;
  assign next_an_en = defaults ? pbm_pkg::AN_EN_RST
    : wr_ctl ? w_an_en : an_enable;
  assign next_pwdn = defaults ? pbm_pkg::PWDN_RST
    : wr_ctl ? pwdata[pbm_pkg::PWDN_BIT] : power_down;
  assign next_duplex_sel = defaults ? pbm_pkg::DUPLEX_RST
    : wr_ctl ? pwdata[pbm_pkg::DUPLEX_BIT] : duplex_sel;

  // control field flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      loopback_en <= pbm_pkg::LOOP_RST;
      speed_sel <= pbm_pkg::SPEED_RST;
      an_enable <= pbm_pkg::AN_EN_RST;
      power_down <= pbm_pkg::PWDN_RST;
      duplex_sel <= pbm_pkg::DUPLEX_RST;
    end else begin
      loopback_en <= next_loop;
      speed_sel <= next_speed_sel;
      an_enable <= next_an_en;
      power_down <= next_pwdn;
      duplex_sel <= next_duplex_sel;
    end
  end

  // restart request; a new request wins over a same-cycle ack,
  // and a written zero never cancels a pending request; the ack is
  // taken as an edge so a level left high cannot clear a new request
  assign next_restart = defaults ? 1'b0
    : restart_set ? 1'b1
    : ack_rise ? 1'b0
    : an_restart;

  // restart request flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      an_restart <= 1'b0;
    end else begin
      an_restart <= next_restart;
    end
  end

  // link mode and rx hold registered so outputs come from flops;
  // the mode therefore follows its sources one cycle late
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_speed_100 <= pbm_pkg::SPEED_RST;
      link_full_duplex <= pbm_pkg::DUPLEX_RST;
      mac_rx_hold <= 1'b0;
    end else begin
      link_speed_100 <= next_speed;
      link_full_duplex <= next_duplex;
      mac_rx_hold <= dead_busy;
    end
  end

endmodule

// *** core/pbm_pkg.sv ***
// constants shared by the basic mode control register block
package pbm_pkg;

  // apb geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CTL_W = 16;

  // byte addresses of the registers
  localparam logic [7:0] CTL_ADDR = 8'h00;
  localparam logic [7:0] STAT_ADDR = 8'h04;

  // control register field positions
  localparam int RST_BIT = 15;
  localparam int LOOP_BIT = 14;
  localparam int SPEED_BIT = 13;
  localparam int AN_EN_BIT = 12;
  localparam int PWDN_BIT = 11;
  localparam int RESTART_BIT = 9;
  localparam int DUPLEX_BIT = 8;

  // status register field positions
  localparam int ST_RST_BUSY = 0;
  localparam int ST_RESTART = 1;
  localparam int ST_DEAD = 2;
  localparam int ST_SPEED = 3;
  localparam int ST_DUPLEX = 4;

  // control field reset values
  localparam logic LOOP_RST = 1'b0;
  localparam logic SPEED_RST = 1'b1;
  localparam logic AN_EN_RST = 1'b1;
  localparam logic PWDN_RST = 1'b0;
  localparam logic DUPLEX_RST = 1'b1;

  // timing
  localparam int unsigned CLK_KHZ = 125000;
  localparam int unsigned DEAD_TIME_MS = 720;
  localparam int unsigned DEAD_CYC = DEAD_TIME_MS * CLK_KHZ;
  localparam int unsigned RST_CYC = 16;

  // number of signals through the input synchronisers
  localparam int SYNC_W = 3;

endpackage

// *** core/pbm_sync.sv ***
// two-flop synchronisers for inputs from the phy side
`timescale 1ns/10ps
module pbm_sync #(
  parameter int W = 3
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // asynchronous inputs and their synchronised copies
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic meta;
      // first stage feeds only the second stage
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          meta <= 1'b0;
          dout[i] <= 1'b0;
        end else begin
          meta <= din[i];
          dout[i] <= meta;
        end
      end
    end
  endgenerate

endmodule

// *** core/pbm_timer.sv ***
// one-shot down counter with busy flag
`timescale 1ns/10ps
module pbm_timer #(
  parameter int unsigned CYCLES = 16
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic start,
  input wire logic clr,
  // busy for exactly CYCLES cycles after start
  output logic busy
);

  localparam int W = $clog2(CYCLES + 1);
  localparam logic [W-1:0] LOAD = W'(CYCLES);
  localparam logic [W-1:0] ONE = W'(1);

  logic [W-1:0] cnt;

  // clear wins over start so a reset can cut a running period short
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= '0;
      busy <= 1'b0;
    end else if (clr) begin
      cnt <= '0;
      busy <= 1'b0;
    end else if (start) begin
      cnt <= LOAD;
      busy <= 1'b1;
    end else if (cnt != '0) begin
      cnt <= cnt - ONE;
      busy <= (cnt > ONE);
    end
  end

endmodule

// *** sim/pbm_an_model.sv ***
// behavioural auto-negotiation engine facing the control block
`timescale 1ns/10ps
module pbm_an_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // request from the block, pacing and result from the bench
  input wire logic an_restart,
  input wire logic slow,
  input wire logic neg_100,
  input wire logic neg_fd,
  // answers to the block
  output logic an_ack,
  output logic an_speed_100,
  output logic an_full_duplex
);
  logic [3:0] wait_cnt;
  // ack drops once the request is gone, so every restart sees a new edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn || !an_restart) begin
      wait_cnt <= 4'h0;
      an_ack <= 1'b0;
    end else if (wait_cnt == (slow ? 4'hf : 4'h2)) begin
      an_ack <= 1'b1;
    end else begin
      wait_cnt <= wait_cnt + 4'h1;
    end
  end
  // negotiated result, static between scenarios
  assign an_speed_100 = neg_100;
  assign an_full_duplex = neg_fd;
endmodule

// *** sim/pbm_monitor.sv ***
// assertions on the ports of the basic mode control block
`timescale 1ns/10ps
module pbm_monitor #(
  parameter int unsigned RST_CYCLES = 16
) (
  // clock, reset and apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // engine and phy side
  input wire logic an_ack,
  input wire logic an_restart,
  input wire logic an_enable,
  input wire logic loopback_en,
  input wire logic power_down,
  input wire logic link_speed_100,
  input wire logic phy_soft_reset,
  input wire logic mac_rx_hold
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // a control write that lands, i.e. not swallowed by a running reset
  wire ctl_wr = pready && pwrite && paddr == 8'h00 && !phy_soft_reset;
  wire [2:0] wr_f = {pwdata[14], pwdata[12], pwdata[11]};
  logic [7:0] rst_len;
  // cycles of the reset pulse so far; repetition cannot take a parameter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) rst_len <= 8'h00;
    else rst_len <= phy_soft_reset ? rst_len + 8'h01 : 8'h00;
  end
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence rd_ctl_s;
    pready && !pwrite && paddr == 8'h00;
  endsequence
  a_unmapped_err: assert property (setup_s ##0 paddr[7:3] != 5'h00
    |=> pslverr && prdata == 32'h0) else $error("no slave error");
  a_rsvd_zero: assert property (rd_ctl_s |-> prdata[31:16] == 16'h0
    && !prdata[10] && prdata[7:0] == 8'h00) else $error("reserved set");
  a_field_write: assert property (ctl_wr && !pwdata[15]
    |=> {loopback_en, an_enable, power_down} == $past(wr_f))
    else $error("field not written");
  a_restart_set: assert property (ctl_wr && pwdata[12] && pwdata[9]
    && !pwdata[15] |=> an_restart) else $error("restart not set");
  a_restart_gate: assert property (ctl_wr && !pwdata[12]
    && !an_restart |=> !an_restart) else $error("restart taken");
  a_restart_keep: assert property ($fell(an_restart)
    |-> $past(an_ack, 2) || phy_soft_reset) else $error("restart lost");
  a_rst_len: assert property ($fell(phy_soft_reset)
    |-> rst_len == RST_CYCLES) else $error("reset length wrong");
  a_rst_default: assert property (phy_soft_reset
    && $past(phy_soft_reset) |-> !loopback_en && !power_down
    && an_enable && !an_restart) else $error("fields not default");
  a_dead_cause: assert property ($rose(mac_rx_hold)
    |-> loopback_en && link_speed_100) else $error("hold without cause");
endmodule

bind pbm_phy_basic_mode_control pbm_monitor #(.RST_CYCLES(RST_CYCLES))
  pbm_monitor_i (.*);

// *** sim/tb.sv ***
// self-checking bench for the basic mode control block
`timescale 1ns/10ps
module tb;
  localparam int unsigned DEAD = 20;
  typedef struct packed {
    logic [31:0] wd;
    logic [15:0] rd;
    logic [4:0] o;
  } pbm_row_s;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic slow = 1'b0;
  logic neg_100 = 1'b1;
  logic neg_fd = 1'b1;
  logic [31:0] prdata, rd;
  logic pready, pslverr, an_ack, an_speed_100, an_full_duplex, err;
  logic phy_soft_reset, loopback_en, link_speed_100, link_full_duplex;
  logic an_enable, an_restart, power_down, mac_rx_hold;
  int err_total = 0;
  int n_tests = 0;
  int k;
  // write, expected readback, expected loop/pdown/an/speed/duplex
  pbm_row_s rows [5] = '{'{32'h0, 16'h0000, 5'b00000},
    '{32'h6100, 16'h6100, 5'b10011}, '{32'h0800, 16'h0800, 5'b01000},
    '{32'hffff06ff, 16'h0000, 5'b00000}, '{32'h1000, 16'h1000, 5'b00100}};
  wire [4:0] outs = {loopback_en, power_down, an_enable, link_speed_100,
    link_full_duplex};
  wire [2:0] watch = {an_restart, phy_soft_reset, mac_rx_hold};
  pbm_phy_basic_mode_control #(.DEAD_CYCLES(DEAD), .RST_CYCLES(8))
    pbm_phy_basic_mode_control_i (.*);
  pbm_an_model pbm_an_model_i (.*);
  initial begin
    forever #4 pclk = ~pclk;
  end
  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one apb transfer; the request stands until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      err_total++;
      results();
    end
  endtask
  // cycles until a watched output falls, bounded
  task automatic wait_clear(input int b, output int n);
    n = 0;
    while (watch[b] !== 1'b0 && n < 200) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 200) begin
      err_total++;
      results();
    end
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h3100);
    chk(outs, 5'b00111);
    neg_100 <= 1'b0;
    neg_fd <= 1'b0;
    foreach (rows[i]) begin
      apb(1'b1, 8'h00, rows[i].wd);
      apb(1'b0, 8'h00, 32'h0);
      chk(rd, rows[i].rd);
      chk(outs, rows[i].o);
    end
    // restart held across a zero write until the slow engine answers
    slow <= 1'b1;
    apb(1'b1, 8'h00, 32'h1200);
    @(negedge pclk);
    chk(an_restart, 1'b1);
    apb(1'b1, 8'h00, 32'h1000);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd[9], 1'b1);
    wait_clear(2, k);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd[9], 1'b0);
    // loopback switched on at forced 100 Mbps
    apb(1'b1, 8'h00, 32'h2000);
    apb(1'b1, 8'h00, 32'h6000);
    @(posedge pclk);
    @(negedge pclk);
    chk(mac_rx_hold, 1'b1);
    wait_clear(0, k);
    chk(k, DEAD + 1);
    apb(1'b0, 8'h08, 32'h0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    // software reset from a non-default state
    neg_100 <= 1'b1;
    neg_fd <= 1'b1;
    apb(1'b1, 8'h00, 32'h4800);
    apb(1'b1, 8'h00, 32'h8000);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'hb100);
    wait_clear(1, k);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h3100);
    chk(outs, 5'b00111);
    // hardware reset in mid-run, taken right after a landed write
    apb(1'b1, 8'h00, 32'h4800);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h3100);
    chk(outs, 5'b00111);
    chk(watch, 3'b000);
    results();
  end
endmodule
